// [svch_pkg.sv]
// package: object indexes, field positions, reset values and timing for the servo mode logic
package svch_pkg;
  // ----------------------------------------------------------------
  // object indexes
  // ----------------------------------------------------------------
  localparam logic [15:0] IX_FUNC_SEL = 16'h200D;
  localparam logic [15:0] IX_SCALE_NUM = 16'h200E;
  localparam logic [15:0] IX_SCALE_DEN = 16'h200F;
  localparam logic [15:0] IX_CTRL = 16'h6040;
  localparam logic [15:0] IX_STATUS = 16'h6041;
  localparam logic [15:0] IX_MODE_REQ = 16'h6060;
  localparam logic [15:0] IX_MODE_DISP = 16'h6061;
  localparam logic [15:0] IX_ACT_POS = 16'h6064;
  localparam logic [15:0] IX_ACT_VEL = 16'h606C;
  localparam logic [15:0] IX_TGT_TQ = 16'h6071;
  localparam logic [15:0] IX_MAX_TQ = 16'h6072;
  localparam logic [15:0] IX_ACT_TQ = 16'h6077;
  localparam logic [15:0] IX_HOME_OFS = 16'h607C;
  localparam logic [15:0] IX_SOFT_LIM = 16'h607D;
  localparam logic [15:0] IX_HOME_METH = 16'h6098;
  localparam logic [15:0] IX_HOME_SPD = 16'h6099;
  localparam logic [15:0] IX_HOME_ACC = 16'h609A;
  localparam logic [15:0] IX_VEL_OFS = 16'h60B1;
  localparam logic [15:0] IX_TQ_OFS = 16'h60B2;
  localparam logic [15:0] IX_POS_TQ_LIM = 16'h60E0;
  localparam logic [15:0] IX_NEG_TQ_LIM = 16'h60E1;
  localparam logic [15:0] IX_TGT_VEL = 16'h60FF;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_FIRST = 8'h01;
  localparam logic [7:0] SUB_SECOND = 8'h02;
  localparam logic [31:0] PAIR_ENTRIES = 32'h0000_0002;
  // ----------------------------------------------------------------
  // control and status fields
  // ----------------------------------------------------------------
  localparam int CTL_HOME_GO = 4;
  localparam int CTL_FAULT_RST = 7;
  localparam int CTL_HALT = 8;
  localparam int ST_FAULT = 3;
  localparam int ST_TGT_REACHED = 10;
  localparam int ST_HOME_DONE = 12;
  localparam int ST_HOME_ERR = 13;
  // ----------------------------------------------------------------
  // modes, reset values, timing
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_NONE = 8'h00;
  localparam logic [7:0] MODE_HOME = 8'h06;
  localparam logic [7:0] MODE_CSV = 8'h09;
  localparam logic [7:0] MODE_CST = 8'h0A;
  localparam logic [31:0] RST_TQ_LIM = 32'h0000_0BB8;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam int CLK_HZ = 50_000_000;
  localparam int MODE_SW_MS = 2;
  localparam int MODE_GAP_MS = 20;
  localparam int STEP_MS = 1;
  localparam int MODE_SW_CYC = MODE_SW_MS * (CLK_HZ / 1000);
  localparam int MODE_GAP_CYC = MODE_GAP_MS * (CLK_HZ / 1000);
  localparam int STEP_CYC = STEP_MS * (CLK_HZ / 1000);
  // homing sequencer states, gray along the usual path
  typedef enum logic [2:0] {
    HM_IDLE = 3'b000, HM_SEARCH = 3'b001, HM_BACKOFF = 3'b011,
    HM_INDEX = 3'b010, HM_DONE = 3'b110, HM_ERR = 3'b111
  } svch_home_e;
  // sensor pins of the axis
  typedef struct packed {
    logic negLim;
    logic posLim;
    logic homeSw;
    logic index;
  } svch_sens_s;
endpackage : svch_pkg

// [svch_servo_modes.sv]
// servo drive cyclic velocity, cyclic torque and homing mode logic
// Overview of operation
// - velocity mode: command follows target velocity plus offset, torque offset fed forward
// - torque mode: command follows target torque, units of one tenth percent
// - max, positive and negative torque limits writable; command clamped within them
// - homing steps position command at configured speeds until home found
// - two unsigned 32-bit homing speeds, switch and zero search; count reads two
// - method 1: move negative, home at first index after negative limit releases
// - method 2: move positive, home at first index after positive limit releases
// - methods 3, 4: direction from home switch, home at index after change
// - methods 5, 6: direction from home switch, home at index after change
// - methods 7, 8: switch active at start means negative start
// - methods 9, 10: switch active at start means positive start
// - methods 11, 12: switch active at start means positive start
// - methods 13, 14: switch active at start means negative start
// - methods 7 to 14: home at index pulse after home switch edge
// - method 17: as method 1, home at the limit switch change
// - method 18: as method 2, home at the limit switch change
// - methods 19, 20: as 3 and 4, home at home switch change
// - mode change completes within two milliseconds; display reads none meanwhile
`timescale 1ns/10ps
`default_nettype none
module svch_servo_modes #(
  parameter int ModeSwCyc = svch_pkg::MODE_SW_CYC,
  parameter int ModeGapCyc = svch_pkg::MODE_GAP_CYC,
  parameter int StepCyc = svch_pkg::STEP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // object access port
  input wire logic objWr,
  input wire logic objRd,
  input wire logic [15:0] objIdx,
  input wire logic [7:0] objSub,
  input wire logic [31:0] objWdata,
  output logic [31:0] objRdata_ff,
  output logic objAck_ff,
  // axis pins, asynchronous
  input wire svch_pkg::svch_sens_s sensPin,
  // feedback from the control loop
  input wire logic signed [31:0] posFb,
  input wire logic signed [31:0] velFb,
  input wire logic signed [15:0] tqFb,
  // commands to the control loop
  output logic signed [31:0] velCmd_ff,
  output logic signed [31:0] tqCmd_ff,
  output logic signed [31:0] homePosCmd_ff,
  output logic homeMoving_ff,
  output logic [7:0] activeMode_ff
);
  // ----------------------------------------------------------------
  // object storage
  // ----------------------------------------------------------------
  logic [15:0] funcSel_ff, scaleNum_ff, scaleDen_ff, ctrl_ff, tgtTq_ff, tqOfs_ff;
  logic [31:0] maxTq_ff, posTqLim_ff, negTqLim_ff, homeOfs_ff, softMin_ff, softMax_ff;
  logic [31:0] swSpd_ff, zeroSpd_ff, homeAcc_ff, velOfs_ff, tgtVel_ff;
  logic [7:0] method_ff, modeReq_ff;
  logic [15:0] prevCtrl_ff;
  logic [15:0] status;
  logic signed [31:0] posOfs_ff;
  logic wr;
  assign wr = objWr;

  // writable objects; torque limits and homing speeds steer the command logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      funcSel_ff <= 16'h0000;
      scaleNum_ff <= 16'h0001;
      scaleDen_ff <= 16'h0001;
      ctrl_ff <= 16'h0000;
      tgtTq_ff <= 16'h0000;
      tqOfs_ff <= 16'h0000;
      maxTq_ff <= svch_pkg::RST_TQ_LIM;
      posTqLim_ff <= svch_pkg::RST_TQ_LIM;
      negTqLim_ff <= svch_pkg::RST_TQ_LIM;
      homeOfs_ff <= svch_pkg::RST_ZERO;
      softMin_ff <= svch_pkg::RST_ZERO;
      softMax_ff <= svch_pkg::RST_ZERO;
      swSpd_ff <= svch_pkg::RST_ZERO;
      zeroSpd_ff <= svch_pkg::RST_ZERO;
      homeAcc_ff <= svch_pkg::RST_ZERO;
      velOfs_ff <= svch_pkg::RST_ZERO;
      tgtVel_ff <= svch_pkg::RST_ZERO;
      method_ff <= 8'h00;
      modeReq_ff <= svch_pkg::MODE_NONE;
    end else if (wr) begin
      case (objIdx)
        svch_pkg::IX_FUNC_SEL: funcSel_ff <= objWdata[15:0];
        svch_pkg::IX_SCALE_NUM: scaleNum_ff <= objWdata[15:0];
        svch_pkg::IX_SCALE_DEN: scaleDen_ff <= objWdata[15:0];
        svch_pkg::IX_CTRL: ctrl_ff <= objWdata[15:0];
        svch_pkg::IX_TGT_TQ: tgtTq_ff <= objWdata[15:0];
        svch_pkg::IX_TQ_OFS: tqOfs_ff <= objWdata[15:0];
        svch_pkg::IX_MAX_TQ: maxTq_ff <= objWdata;
        svch_pkg::IX_POS_TQ_LIM: posTqLim_ff <= objWdata;
        svch_pkg::IX_NEG_TQ_LIM: negTqLim_ff <= objWdata;
        svch_pkg::IX_HOME_OFS: homeOfs_ff <= objWdata;
        svch_pkg::IX_SOFT_LIM: begin
          if (objSub == svch_pkg::SUB_FIRST) softMin_ff <= objWdata;
          if (objSub == svch_pkg::SUB_SECOND) softMax_ff <= objWdata;
        end
        svch_pkg::IX_HOME_SPD: begin
          if (objSub == svch_pkg::SUB_FIRST) swSpd_ff <= objWdata;
          if (objSub == svch_pkg::SUB_SECOND) zeroSpd_ff <= objWdata;
        end
        svch_pkg::IX_HOME_ACC: homeAcc_ff <= objWdata;
        svch_pkg::IX_VEL_OFS: velOfs_ff <= objWdata;
        svch_pkg::IX_TGT_VEL: tgtVel_ff <= objWdata;
        svch_pkg::IX_HOME_METH: method_ff <= objWdata[7:0];
        svch_pkg::IX_MODE_REQ: modeReq_ff <= objWdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers and edge history
  // ----------------------------------------------------------------
  svch_pkg::svch_sens_s sMeta_ff, sens_ff, sensDly_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sMeta_ff <= '0;
      sens_ff <= '0;
      sensDly_ff <= '0;
    end else begin
      sMeta_ff <= sensPin;
      sens_ff <= sMeta_ff;
      sensDly_ff <= sens_ff; // edge history reads only the second stage
    end
  end
  logic idxRise;
  assign idxRise = sens_ff.index && !sensDly_ff.index;

  // ----------------------------------------------------------------
  // mode switching
  // ----------------------------------------------------------------
  logic [16:0] swCnt_ff;
  logic [20:0] gapCnt_ff;
  logic modeFault_ff, modeBusy_ff;
  logic [7:0] pendMode_ff;
  logic modeKick;
  // zero keeps the previous mode, so it never starts a change
  assign modeKick = wr && objIdx == svch_pkg::IX_MODE_REQ &&
                    objWdata[7:0] != svch_pkg::MODE_NONE && objWdata[7:0] != activeMode_ff;

  // change takes the settle time; active mode reads none while settling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      swCnt_ff <= 17'h00000;
      modeBusy_ff <= 1'b0;
      pendMode_ff <= svch_pkg::MODE_NONE;
      activeMode_ff <= svch_pkg::MODE_NONE;
    end else if (modeKick) begin
      swCnt_ff <= 17'(ModeSwCyc - 1);
      modeBusy_ff <= 1'b1;
      pendMode_ff <= objWdata[7:0];
      activeMode_ff <= svch_pkg::MODE_NONE;
    end else if (modeBusy_ff) begin
      swCnt_ff <= swCnt_ff - 17'h00001;
      if (swCnt_ff == 17'h00000) begin
        modeBusy_ff <= 1'b0;
        activeMode_ff <= pendMode_ff;
      end
    end
  end

  // changes too close together latch a fault; a new change beats the reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gapCnt_ff <= 21'h000000;
      modeFault_ff <= 1'b0;
    end else begin
      if (modeKick) gapCnt_ff <= 21'(ModeGapCyc);
      else if (gapCnt_ff != 21'h000000) gapCnt_ff <= gapCnt_ff - 21'h000001;
      if (modeKick && gapCnt_ff != 21'h000000) modeFault_ff <= 1'b1;
      else if (wr && objIdx == svch_pkg::IX_CTRL && objWdata[svch_pkg::CTL_FAULT_RST])
        modeFault_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // cyclic velocity and torque commands
  // ----------------------------------------------------------------
  logic signed [31:0] hiCap, loCap, tqSum, velSum;
  assign hiCap = ($signed(maxTq_ff) < $signed(posTqLim_ff)) ? $signed(maxTq_ff)
                                                             : $signed(posTqLim_ff);
  assign loCap = ($signed(maxTq_ff) < $signed(negTqLim_ff)) ? -$signed(maxTq_ff)
                                                             : -$signed(negTqLim_ff);
  assign velSum = $signed(tgtVel_ff) + $signed(velOfs_ff);
  assign tqSum = (activeMode_ff == svch_pkg::MODE_CST)
               ? 32'($signed(tgtTq_ff)) + 32'($signed(tqOfs_ff))
               : 32'($signed(tqOfs_ff));

  // torque is bounded in both cyclic modes and zero otherwise, the offset alone in velocity mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      velCmd_ff <= '0;
      tqCmd_ff <= '0;
    end else begin
      velCmd_ff <= (activeMode_ff == svch_pkg::MODE_CSV) ? velSum : '0;
      if (activeMode_ff != svch_pkg::MODE_CST && activeMode_ff != svch_pkg::MODE_CSV)
        tqCmd_ff <= '0;
      else if (tqSum > hiCap) tqCmd_ff <= hiCap;
      else if (tqSum < loCap) tqCmd_ff <= loCap;
      else tqCmd_ff <= tqSum;
    end
  end

  // ----------------------------------------------------------------
  // homing method decode
  // ----------------------------------------------------------------
  logic limMeth, edgeOnly, known, startDir;
  logic watched;
  always_comb begin
    limMeth = 1'b0;
    edgeOnly = 1'b0;
    known = 1'b1;
    startDir = !sens_ff.homeSw;
    watched = sens_ff.homeSw;
    case (method_ff)
      8'h01, 8'h11: begin
        limMeth = 1'b1;
        startDir = 1'b0;
        watched = sens_ff.negLim;
        edgeOnly = method_ff == 8'h11;
      end
      8'h02, 8'h12: begin
        limMeth = 1'b1;
        startDir = 1'b1;
        watched = sens_ff.posLim;
        edgeOnly = method_ff == 8'h12;
      end
      8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h0D, 8'h0E: startDir = !sens_ff.homeSw;
      8'h05, 8'h09, 8'h0A, 8'h0B, 8'h0C: startDir = sens_ff.homeSw;
      8'h13, 8'h14: edgeOnly = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // homing sequencer
  // ----------------------------------------------------------------
  svch_pkg::svch_home_e hm_ff;
  logic dir_ff, startLvl_ff, edgeOnly_ff, limMeth_ff, goEdge, halt;
  assign goEdge = ctrl_ff[svch_pkg::CTL_HOME_GO] && !prevCtrl_ff[svch_pkg::CTL_HOME_GO];
  assign halt = ctrl_ff[svch_pkg::CTL_HALT] || activeMode_ff != svch_pkg::MODE_HOME;
  logic travelLim;
  assign travelLim = dir_ff ? sens_ff.posLim : sens_ff.negLim;

  // searches toward the switch, then finds home at the edge or next index
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hm_ff <= svch_pkg::HM_IDLE;
      dir_ff <= 1'b0;
      startLvl_ff <= 1'b0;
      edgeOnly_ff <= 1'b0;
      limMeth_ff <= 1'b0;
      prevCtrl_ff <= 16'h0000;
    end else begin
      prevCtrl_ff <= ctrl_ff;
      if (halt) hm_ff <= svch_pkg::HM_IDLE;
      else if (goEdge) begin
        startLvl_ff <= watched;
        edgeOnly_ff <= edgeOnly;
        limMeth_ff <= limMeth;
        if (!known) hm_ff <= svch_pkg::HM_ERR;
        else if (limMeth && watched) begin
          hm_ff <= svch_pkg::HM_BACKOFF; // already on the limit
          dir_ff <= !startDir;
        end else begin
          hm_ff <= svch_pkg::HM_SEARCH;
          dir_ff <= startDir;
        end
      end else begin
        case (hm_ff)
          svch_pkg::HM_SEARCH:
            if (limMeth_ff && watched) begin
              hm_ff <= svch_pkg::HM_BACKOFF;
              dir_ff <= !dir_ff;
            end else if (!limMeth_ff && watched != startLvl_ff)
              hm_ff <= edgeOnly_ff ? svch_pkg::HM_DONE : svch_pkg::HM_INDEX;
            else if (!limMeth_ff && travelLim)
              hm_ff <= svch_pkg::HM_ERR; // switch missed before the end stop
          svch_pkg::HM_BACKOFF:
            if (!watched)
              hm_ff <= edgeOnly_ff ? svch_pkg::HM_DONE : svch_pkg::HM_INDEX;
          svch_pkg::HM_INDEX:
            if (idxRise) hm_ff <= svch_pkg::HM_DONE;
          default: ;
        endcase
      end
    end
  end

  // position command steps once per interval; switch speed while searching
  logic [15:0] stepCnt_ff;
  logic moving;
  assign moving = hm_ff == svch_pkg::HM_SEARCH || hm_ff == svch_pkg::HM_BACKOFF ||
                  hm_ff == svch_pkg::HM_INDEX;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stepCnt_ff <= 16'h0000;
      homePosCmd_ff <= '0;
      homeMoving_ff <= 1'b0;
    end else begin
      homeMoving_ff <= moving && !halt;
      if (goEdge) homePosCmd_ff <= posFb;
      if (!moving || stepCnt_ff == 16'(StepCyc - 1)) stepCnt_ff <= 16'h0000;
      else stepCnt_ff <= stepCnt_ff + 16'h0001;
      if (moving && !goEdge && stepCnt_ff == 16'(StepCyc - 1)) begin
        if (dir_ff) homePosCmd_ff <= homePosCmd_ff +
          $signed(hm_ff == svch_pkg::HM_SEARCH ? swSpd_ff : zeroSpd_ff);
        else homePosCmd_ff <= homePosCmd_ff -
          $signed(hm_ff == svch_pkg::HM_SEARCH ? swSpd_ff : zeroSpd_ff);
      end
    end
  end

  // home position takes the home offset; the correction sticks afterward
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) posOfs_ff <= '0;
    else if (hm_ff != svch_pkg::HM_DONE && !halt && !goEdge && (
             (hm_ff == svch_pkg::HM_INDEX && idxRise) ||
             (hm_ff == svch_pkg::HM_BACKOFF && !watched && edgeOnly_ff) ||
             (hm_ff == svch_pkg::HM_SEARCH && !limMeth_ff && edgeOnly_ff &&
              watched != startLvl_ff)))
      posOfs_ff <= $signed(homeOfs_ff) - posFb;
  end

  // ----------------------------------------------------------------
  // status and read-back
  // ----------------------------------------------------------------
  always_comb begin
    status = 16'h0000;
    status[svch_pkg::ST_FAULT] = modeFault_ff;
    status[svch_pkg::ST_TGT_REACHED] = hm_ff == svch_pkg::HM_DONE;
    status[svch_pkg::ST_HOME_DONE] = hm_ff == svch_pkg::HM_DONE;
    status[svch_pkg::ST_HOME_ERR] = hm_ff == svch_pkg::HM_ERR;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      objRdata_ff <= '0;
      objAck_ff <= 1'b0;
    end else begin
      objAck_ff <= objRd || objWr;
      objRdata_ff <= '0;
      if (objRd) begin
        case (objIdx)
          svch_pkg::IX_FUNC_SEL: objRdata_ff <= {16'h0000, funcSel_ff};
          svch_pkg::IX_SCALE_NUM: objRdata_ff <= {16'h0000, scaleNum_ff};
          svch_pkg::IX_SCALE_DEN: objRdata_ff <= {16'h0000, scaleDen_ff};
          svch_pkg::IX_CTRL: objRdata_ff <= {16'h0000, ctrl_ff};
          svch_pkg::IX_STATUS: objRdata_ff <= {16'h0000, status};
          svch_pkg::IX_MODE_REQ: objRdata_ff <= {24'h000000, modeReq_ff};
          svch_pkg::IX_MODE_DISP: objRdata_ff <= {24'h000000, activeMode_ff};
          svch_pkg::IX_ACT_POS: objRdata_ff <= posFb + posOfs_ff;
          svch_pkg::IX_ACT_VEL: objRdata_ff <= velFb;
          svch_pkg::IX_TGT_TQ: objRdata_ff <= {16'h0000, tgtTq_ff};
          svch_pkg::IX_MAX_TQ: objRdata_ff <= maxTq_ff;
          svch_pkg::IX_ACT_TQ: objRdata_ff <= {16'h0000, tqFb};
          svch_pkg::IX_HOME_OFS: objRdata_ff <= homeOfs_ff;
          svch_pkg::IX_SOFT_LIM: objRdata_ff <= objSub == svch_pkg::SUB_COUNT ?
            svch_pkg::PAIR_ENTRIES : objSub == svch_pkg::SUB_FIRST ? softMin_ff : softMax_ff;
          svch_pkg::IX_HOME_METH: objRdata_ff <= {24'h000000, method_ff};
          svch_pkg::IX_HOME_SPD: objRdata_ff <= objSub == svch_pkg::SUB_COUNT ?
            svch_pkg::PAIR_ENTRIES : objSub == svch_pkg::SUB_FIRST ? swSpd_ff : zeroSpd_ff;
          svch_pkg::IX_HOME_ACC: objRdata_ff <= homeAcc_ff;
          svch_pkg::IX_VEL_OFS: objRdata_ff <= velOfs_ff;
          svch_pkg::IX_TQ_OFS: objRdata_ff <= {16'h0000, tqOfs_ff};
          svch_pkg::IX_POS_TQ_LIM: objRdata_ff <= posTqLim_ff;
          svch_pkg::IX_NEG_TQ_LIM: objRdata_ff <= negTqLim_ff;
          svch_pkg::IX_TGT_VEL: objRdata_ff <= tgtVel_ff;
          default: objRdata_ff <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic cst, csv;
  assign cst = activeMode_ff == svch_pkg::MODE_CST;
  assign csv = activeMode_ff == svch_pkg::MODE_CSV;
  a_tq_upper_cap: assert property (cst |=> tqCmd_ff <= $past(hiCap))
    else $error("torque above upper cap");
  a_tq_lower_cap: assert property (cst |=> tqCmd_ff >= $past(loCap))
    else $error("torque below lower cap");
  a_tq_follow: assert property (cst && tqSum <= hiCap && tqSum >= loCap
    |=> tqCmd_ff == $past(tqSum))
    else $error("torque not following target");
  a_vel_follow: assert property (csv |=> velCmd_ff == $past(velSum))
    else $error("velocity not following target");
  a_mode_settle: assert property (modeKick |=> modeBusy_ff[*8])
    else $error("mode settled too early");
  a_gap_fault: assert property (modeKick && gapCnt_ff != 21'h000000 |=> modeFault_ff)
    else $error("close mode change not flagged");
  a_m1_start: assert property (goEdge && !halt && method_ff == 8'h01 && !sens_ff.negLim
    |=> hm_ff == svch_pkg::HM_SEARCH && !dir_ff)
    else $error("method one start wrong");
  a_index_home: assert property (hm_ff == svch_pkg::HM_INDEX && idxRise && !halt && !goEdge
    |=> hm_ff == svch_pkg::HM_DONE ##1 status[svch_pkg::ST_HOME_DONE])
    else $error("index did not complete homing");
  a_edge_home: assert property (hm_ff == svch_pkg::HM_BACKOFF && edgeOnly_ff && !watched
    && !halt && !goEdge |=> hm_ff == svch_pkg::HM_DONE)
    else $error("limit edge did not complete homing");
  a_pair_count: assert property (objRd && objIdx == svch_pkg::IX_HOME_SPD &&
    objSub == svch_pkg::SUB_COUNT |=> objRdata_ff == svch_pkg::PAIR_ENTRIES)
    else $error("speed pair count wrong");
  c_home_done: cover property (hm_ff == svch_pkg::HM_INDEX ##1 hm_ff == svch_pkg::HM_DONE);
  c_tq_clamped: cover property (cst && tqSum > hiCap);
  c_mode_fault: cover property ($rose(modeFault_ff));
  c_home_err: cover property (hm_ff == svch_pkg::HM_ERR);
endmodule : svch_servo_modes
`default_nettype wire

// [svch_master_model.sv]
// fieldbus master model: object accesses and spaced mode requests
`timescale 1ns/10ps
`default_nettype none
module svch_master_model #(parameter int Gap = 100) (
  // clock
  input wire logic clk,
  // object port
  output logic objWr,
  output logic objRd,
  output logic [15:0] objIdx,
  output logic [7:0] objSub,
  output logic [31:0] objWdata,
  input wire logic [31:0] objRdata_ff
);
  logic [31:0] rv;
  // idle port from time zero
  initial {objWr, objRd, objIdx, objSub, objWdata} = '0;
  // one access: strobe after a falling edge, answer taken one cycle later
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                     input logic [31:0] d);
    @(negedge clk);
    {objWr, objRd, objIdx, objSub, objWdata} = {w, !w, i, s, d};
    @(negedge clk);
    {objWr, objRd} = 2'b00;
    rv = objRdata_ff;
  endtask : acc
  // mode request; unspaced for the first change and where a fast-switch fault is wanted
  task automatic mode(input logic [7:0] md, input logic spaced);
    if (spaced) repeat (Gap + 2) @(negedge clk);
    acc(1'b1, svch_pkg::IX_MODE_REQ, 8'h00, {24'h0, md});
  endtask : mode
endmodule : svch_master_model
`default_nettype wire

// [svch_servo_modes_test.sv]
// testbench: objects, cyclic velocity and torque, mode switching, homing
`timescale 1ns/10ps
`default_nettype none
module svch_servo_modes_test;
  localparam int SwC = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic objWr, objRd, objAck_ff, homeMoving_ff;
  logic [15:0] objIdx;
  logic [7:0] objSub, activeMode_ff;
  logic [31:0] objWdata, objRdata_ff, d0, d1;
  logic signed [31:0] velFb = 32'sh0;
  logic signed [31:0] velCmd_ff, tqCmd_ff, homePosCmd_ff;
  logic signed [15:0] tqFb = 16'sh0;
  wire signed [31:0] posFb = homePosCmd_ff;
  svch_pkg::svch_sens_s sensPin = '0;
  int err_total = 0;
  int cmp_count = 0;
  int t;
  int meth[7] = '{1, 2, 17, 18, 5, 20, 15};
  always #10 clk = ~clk;
  svch_servo_modes #(.ModeSwCyc(SwC), .ModeGapCyc(100), .StepCyc(4)) dut (
    .clk(clk), .rst_n(rst_n), .objWr(objWr), .objRd(objRd),
    .objIdx(objIdx), .objSub(objSub), .objWdata(objWdata),
    .objRdata_ff(objRdata_ff), .objAck_ff(objAck_ff), .sensPin(sensPin),
    .posFb(posFb), .velFb(velFb), .tqFb(tqFb),
    .velCmd_ff(velCmd_ff), .tqCmd_ff(tqCmd_ff), .homePosCmd_ff(homePosCmd_ff),
    .homeMoving_ff(homeMoving_ff), .activeMode_ff(activeMode_ff)
  );
  svch_master_model #(.Gap(100)) m (
    .clk(clk), .objWr(objWr), .objRd(objRd), .objIdx(objIdx),
    .objSub(objSub), .objWdata(objWdata), .objRdata_ff(objRdata_ff)
  );
  // axis: limits past +-256, home switch below zero, index every 64 counts
  always @(negedge clk) sensPin <= {posFb < -256, posFb > 256, posFb < 0, posFb[5:0] == 6'h00};
  // report a mismatch at once
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
    m.acc(1'b0, i, s, 32'h0);
    chk(m.rv, e);
    chk(objAck_ff, 1'b1);
  endtask : rd
  // torque window of the bench model
  function automatic int clip(int v, int hi, int lo);
    return (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction : clip
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // watchdog well beyond the expected run
  initial begin
    #400_000;
    err_total++;
    final_report();
  end
  initial begin
    void'($urandom(32'h33D1));
    velFb = $urandom;
    tqFb = 16'($urandom);
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    rd(svch_pkg::IX_MAX_TQ, 8'h00, svch_pkg::RST_TQ_LIM);
    rd(svch_pkg::IX_HOME_SPD, svch_pkg::SUB_COUNT, svch_pkg::PAIR_ENTRIES);
    m.acc(1'b1, svch_pkg::IX_ACT_VEL, 8'h00, 32'h1);
    rd(svch_pkg::IX_ACT_VEL, 8'h00, velFb);
    rd(svch_pkg::IX_ACT_TQ, 8'h00, {16'h0000, tqFb});
    rd(16'h1234, 8'h00, 32'h0);
    d0 = 32'h10 << ($urandom & 1);
    m.acc(1'b1, svch_pkg::IX_HOME_SPD, svch_pkg::SUB_FIRST, d0);
    rd(svch_pkg::IX_HOME_SPD, svch_pkg::SUB_FIRST, d0);
    // a zero search speed would leave the back-off and index phases standing still
    m.acc(1'b1, svch_pkg::IX_HOME_SPD, svch_pkg::SUB_SECOND, 32'h8);
    rd(svch_pkg::IX_HOME_SPD, svch_pkg::SUB_SECOND, 32'h8);
    $display("test objects done");
    m.mode(svch_pkg::MODE_CSV, 1'b0);
    chk(activeMode_ff, 32'h0);
    d0 = $urandom;
    d1 = $urandom;
    m.acc(1'b1, svch_pkg::IX_TGT_VEL, 8'h00, d0);
    m.acc(1'b1, svch_pkg::IX_VEL_OFS, 8'h00, d1);
    m.acc(1'b1, svch_pkg::IX_TQ_OFS, 8'h00, 32'h64);
    repeat (SwC) @(negedge clk);
    chk(activeMode_ff, svch_pkg::MODE_CSV);
    chk(velCmd_ff, d0 + d1);
    chk(tqCmd_ff, 32'h64);
    m.mode(svch_pkg::MODE_CST, 1'b1);
    m.acc(1'b1, svch_pkg::IX_MAX_TQ, 8'h00, 32'h3E8);
    m.acc(1'b1, svch_pkg::IX_POS_TQ_LIM, 8'h00, 32'h320);
    m.acc(1'b1, svch_pkg::IX_NEG_TQ_LIM, 8'h00, 32'h258);
    repeat (SwC) @(negedge clk);
    for (t = 0; t < 4; t++) begin
      d0 = $urandom_range(4000) - 2000;
      m.acc(1'b1, svch_pkg::IX_TGT_TQ, 8'h00, d0);
      repeat (3) @(negedge clk);
      chk(tqCmd_ff, clip(int'(d0) + 100, 800, -600));
    end
    $display("test cyclic modes done");
    // a second change inside the spacing window raises the fault
    m.mode(svch_pkg::MODE_HOME, 1'b0);
    m.acc(1'b0, svch_pkg::IX_STATUS, 8'h00, 32'h0);
    chk(m.rv[svch_pkg::ST_FAULT], 1'b1);
    m.acc(1'b1, svch_pkg::IX_CTRL, 8'h00, 32'h80);
    m.acc(1'b0, svch_pkg::IX_STATUS, 8'h00, 32'h0);
    chk(m.rv[svch_pkg::ST_FAULT], 1'b0);
    m.mode(svch_pkg::MODE_HOME, 1'b1);
    repeat (SwC) @(negedge clk);
    chk(activeMode_ff, svch_pkg::MODE_HOME);
    // a random home offset; a stopped axis must then read back exactly this position
    d0 = $urandom;
    m.acc(1'b1, svch_pkg::IX_HOME_OFS, 8'h00, d0);
    // each run is halted to idle first, then started by a rising go bit
    // method 20 starts on the active switch, moves negative without ever leaving it and hits the end stop
    for (t = 0; t < 7; t++) begin
      m.acc(1'b1, svch_pkg::IX_HOME_METH, 8'h00, meth[t]);
      m.acc(1'b1, svch_pkg::IX_CTRL, 8'h00, 32'h100);
      m.acc(1'b1, svch_pkg::IX_CTRL, 8'h00, 32'h10);
      d1 = 32'h0;
      repeat (500) begin
        if (d1 == 32'h0) begin
          m.acc(1'b0, svch_pkg::IX_STATUS, 8'h00, 32'h0);
          d1 = m.rv & 32'h3000;
        end
      end
      chk(d1, (t < 5) ? 32'h1000 : 32'h2000);
      chk(homeMoving_ff, 1'b0);
      if (t < 5) rd(svch_pkg::IX_ACT_POS, 8'h00, d0);
    end
    $display("test homing done");
    final_report();
  end
endmodule : svch_servo_modes_test
`default_nettype wire
